/* sld_lock_align.sv */
// Lock detection and word alignment for a multi-rate serial video receiver
`timescale 1ns/1ns
`include "sld_regs.svh"

// Functional notes
// [R1] System supplies a 27MHz reference by crystal or clock into one pin.
// [R2] Lock shows on status pin three by default, movable to any of six.
// [R3] Data-through mode: lock follows reclocker PLL lock alone.
// [R4] SMPTE mode: lock needs PLL lock and two TRS within two lines.
// [R5] Noise immunity in auto mode: last two TRS must share alignment.
// [R6] ASI mode: lock needs PLL lock and 32 good words in 128; the code needs the 32 in a row within one window.
// [R7] Standby holds the lock indication at its previous value.
// [R8] Lock search starts at reset release and runs continuously.
// [R9] Without a valid serial stream the lock indication stays low.
// [R10] After valid input, hunt for TRS or ASI sync words.
// [R11] Auto rate mode is default and cycles 3G, HD, SD while hunting.
// [R12] Manual rate mode holds the selected rate, lock within three lines.
// [R13] Gaps up to 10us tolerated; longer gaps drop rate and lock.
// [R14] NRZI to NRZ conversion and descrambling precede word alignment.
// [R15] Manual mode aligns only with processing enabled and ASI low.
// [R16] Auto mode commits alignment after two TRS with equal alignment.
// [R17] TRS checking is continuous; SMPTE lock ends when TRS stop.
// [R18] Both 8-bit and 10-bit TRS headers are recognised.
// [R19] Level B width mismatch: no alignment, stay in data-through.
// [R20] Descrambler uses x^9+x^4+1 after the x+1 NRZI decode.
// [R21] TRS preamble is one all-ones word then two all-zeros words.
module sld_lock_align #(
	parameter int LINE_BITS_SD = 17160,
	parameter int LINE_BITS_HD = 44000,
	parameter int LINE_BITS_3G = 88000
) (
	// Clock and reset
	input  wire logic        I_CORE_CLK,
	input  wire logic        I_RST_N,
	// APB slave
	input  wire logic        I_PSEL,
	input  wire logic        I_PENABLE,
	input  wire logic        I_PWRITE,
	input  wire logic [11:0] I_PADDR,
	input  wire logic [31:0] I_PWDATA,
	output logic      [31:0] O_PRDATA,
	output logic             O_PREADY,
	output logic             O_PSLVERR,
	// Recovered serial link
	input  wire logic        I_SER_CLK,
	input  wire logic        I_SER_DATA,
	// Mode and status pins
	input  wire logic        I_PLL_LOCKED,
	input  wire logic        I_VIDEO_PROCESSING_ENABLE,
	input  wire logic        I_ASI_MODE_SELECT,
	input  wire logic        I_STANDBY,
	input  wire logic        I_LEVEL_B_WIDTH_MISMATCH,
	// Lock and aligned words
	output logic       [5:0] O_STAT,
	output logic             O_LOCKED,
	output logic       [1:0] O_RATE,
	output logic       [9:0] O_WORD,
	output logic             O_WORD_VALID
);

	// ************************************************************
	// Helpers
	// ************************************************************
	function automatic logic trs_match(input logic [29:0] h,
		input logic ten);
		trs_match = (h[9:2] == 8'hFF) && (h[19:12] == 8'h00)
			&& (h[29:22] == 8'h00) && (!ten || ((h[1:0] == 2'h3)
			&& (h[11:10] == 2'h0) && (h[21:20] == 2'h0)));
	endfunction

	function automatic logic [18:0] line_len(
		input sld_pkg::sld_rate_t r, input int n);
		case (r)
			sld_pkg::SLD_RT_SD: line_len = 19'(LINE_BITS_SD * n);
			sld_pkg::SLD_RT_3G: line_len = 19'(LINE_BITS_3G * n);
			default:            line_len = 19'(LINE_BITS_HD * n);
		endcase
	endfunction

	function automatic logic ones_ok(input logic [9:0] w);
		logic [3:0] n;
		n = 4'h0;
		for (int i = 0; i < 10; i++)
			n = 4'(n + 4'(w[i]));
		ones_ok = (n >= 4'h4) && (n <= 4'h6);
	endfunction

	localparam logic [9:0] GAP_CYC  = 10'(`SLD_GAP_CYC);
	localparam logic [5:0] ASI_RUN  = 6'(`SLD_ASI_RUN);
	localparam logic [6:0] WIN_LAST = 7'(`SLD_ASI_WIN - 1);

	// ************************************************************
	// Pin synchroniser
	// ************************************************************
	sld_pkg::sld_pins_t pin_in;
	sld_pkg::sld_pins_t s1_reg;
	sld_pkg::sld_pins_t s2_reg;
	sld_pkg::sld_ctrl_t ctrl_reg;

	assign pin_in = {I_SER_CLK, I_SER_DATA, I_PLL_LOCKED,
		I_VIDEO_PROCESSING_ENABLE, I_ASI_MODE_SELECT, I_STANDBY,
		I_LEVEL_B_WIDTH_MISMATCH};

	always_ff @(posedge I_CORE_CLK) begin
		if (!I_RST_N) begin
			s1_reg <= '0;
			s2_reg <= '0;
		end else begin
			s1_reg <= pin_in;
			s2_reg <= s1_reg;
		end
	end

	wire pll  = s2_reg.pll;
	wire vpe  = s2_reg.vpe;
	wire asi  = s2_reg.asi;
	wire stby = s2_reg.stby;
	wire mism = s2_reg.mism;
	wire dthru_m = !asi && (!vpe || mism);
	wire smpte_m = !asi && vpe && !mism;
	wire asi_m   = asi && !vpe;

	// ************************************************************
	// Bit recovery, NRZI decode and descrambling
	// ************************************************************
	logic        clk_d_reg;
	logic        chk_reg;
	logic        prev_reg;
	logic [8:0]  scr_reg;
	logic [31:0] hist_reg;
	logic [9:0]  raw_reg;
	logic [3:0]  ph_reg;
	logic [9:0]  act_reg;

	// The link clock is only sampled, so each bit costs a full edge
	wire bit_en = s2_reg.ser_clk & ~clk_d_reg;
	wire nrz    = s2_reg.ser_data ^ prev_reg; // [R14] [R20]
	wire descr  = nrz ^ scr_reg[3] ^ scr_reg[8]; // [R14] [R20]
	wire [3:0] ph_next = (ph_reg == 4'h9) ? 4'h0 : 4'(ph_reg + 4'h1);
	wire stream_valid = act_reg < GAP_CYC;
	wire [9:0] act_next = bit_en ? 10'h000 :
		(stream_valid ? 10'(act_reg + 10'h001) : act_reg);

	always_ff @(posedge I_CORE_CLK) begin
		if (!I_RST_N) begin
			clk_d_reg <= 1'b0;
			chk_reg   <= 1'b0;
			prev_reg  <= 1'b0;
			scr_reg   <= '0;
			hist_reg  <= '0;
			raw_reg   <= '0;
			ph_reg    <= 4'h0;
			act_reg   <= GAP_CYC;
		end else begin
			clk_d_reg <= s2_reg.ser_clk;
			chk_reg   <= bit_en;
			act_reg   <= act_next; // [R13]
			if (bit_en) begin
				prev_reg <= s2_reg.ser_data;
				scr_reg  <= {scr_reg[7:0], nrz};
				hist_reg <= {descr, hist_reg[31:1]};
				raw_reg  <= {s2_reg.ser_data, raw_reg[9:1]};
				ph_reg   <= ph_next;
			end
		end
	end

	// ************************************************************
	// TRS detection and word alignment
	// ************************************************************
	sld_pkg::sld_rate_t rate_reg;
	logic [18:0] gap_reg;
	logic        have_reg;
	logic        pair_reg;
	logic        pair_al_reg;
	logic        aligned_reg;
	logic [3:0]  last_ph_reg;
	logic [3:0]  align_ph_reg;

	wire [18:0] win2 = line_len(rate_reg, 2);
	wire [18:0] win3 = line_len(rate_reg, `SLD_HUNT_LINES);
	// A 10-bit header after a set bit also looks like an 8-bit one a bit
	// or two early; each window is judged two bits late to tell them apart
	wire ten_now  = trs_match(hist_reg[29:0], 1'b1);
	wire ten_late = trs_match(hist_reg[30:1], 1'b1)
		|| trs_match(hist_reg[31:2], 1'b1);
	wire trs_hit = chk_reg && (ten_now
		|| (trs_match(hist_reg[29:0], 1'b0) && !ten_late)); // [R18] [R21]
	wire in_win   = gap_reg <= win2;
	wire trs_lost = gap_reg > win2; // [R17]
	wire same_al  = have_reg && (ph_reg == last_ph_reg);
	wire align_en = !mism
		&& (ctrl_reg.auto_rate || (vpe && !asi)); // [R15] [R19]

	always_ff @(posedge I_CORE_CLK) begin
		if (!I_RST_N || !stream_valid) begin
			gap_reg      <= '0;
			have_reg     <= 1'b0;
			pair_reg     <= 1'b0;
			pair_al_reg  <= 1'b0;
			aligned_reg  <= 1'b0;
			last_ph_reg  <= 4'h0;
			align_ph_reg <= 4'h0;
		end else begin
			if (bit_en && !trs_lost)
				gap_reg <= 19'(gap_reg + 19'h00001);
			if (trs_lost) begin
				have_reg <= 1'b0; // [R17]
				pair_reg <= 1'b0; // [R17]
			end
			if (trs_lost || !align_en)
				aligned_reg <= 1'b0;
			// A hit in the same cycle as a loss wins
			if (trs_hit) begin
				gap_reg     <= '0;
				have_reg    <= 1'b1;
				last_ph_reg <= ph_reg;
				pair_reg    <= have_reg && in_win; // [R4]
				pair_al_reg <= same_al; // [R5]
				if (same_al && in_win && align_en) begin
					aligned_reg  <= 1'b1; // [R16]
					align_ph_reg <= ph_reg; // [R16]
				end
			end
		end
	end

	// ************************************************************
	// ASI sync and error-free word window
	// ************************************************************
	logic       asi_al_reg;
	logic [3:0] asi_ph_reg;
	logic [6:0] win_reg;
	logic [5:0] run_reg;
	logic       hit_reg;
	logic       asi_ok_reg;

	wire comma = chk_reg && ((raw_reg == `SLD_K28_NEG)
		|| (raw_reg == `SLD_K28_POS)); // [R10]
	wire asi_word = chk_reg && asi_al_reg && (ph_reg == asi_ph_reg);
	wire [5:0] run_next = !ones_ok(raw_reg) ? 6'h00 :
		((run_reg == ASI_RUN) ? run_reg : 6'(run_reg + 6'h01));

	always_ff @(posedge I_CORE_CLK) begin
		if (!I_RST_N || !stream_valid || !asi) begin
			asi_al_reg <= 1'b0;
			asi_ph_reg <= 4'h0;
			win_reg    <= '0;
			run_reg    <= '0;
			hit_reg    <= 1'b0;
			asi_ok_reg <= 1'b0;
		end else begin
			if (comma) begin
				asi_al_reg <= 1'b1;
				asi_ph_reg <= ph_reg;
			end
			if (asi_word) begin
				win_reg <= 7'(win_reg + 7'h01);
				run_reg <= run_next;
				if (run_next == ASI_RUN) begin
					hit_reg    <= 1'b1; // [R6]
					asi_ok_reg <= 1'b1; // [R6]
				end
				if (win_reg == WIN_LAST) begin
					run_reg <= '0;
					hit_reg <= 1'b0;
					if (!hit_reg && run_next != ASI_RUN)
						asi_ok_reg <= 1'b0; // [R6]
				end
			end
		end
	end

	// ************************************************************
	// Rate selection and hunt
	// ************************************************************
	logic [18:0] hunt_reg;
	sld_pkg::sld_state_t st_reg;
	sld_pkg::sld_state_t st_next;

	wire sld_pkg::sld_rate_t rate_step =
		(rate_reg == sld_pkg::SLD_RT_3G) ? sld_pkg::SLD_RT_HD :
		(rate_reg == sld_pkg::SLD_RT_HD) ? sld_pkg::SLD_RT_SD :
		sld_pkg::SLD_RT_3G;
	wire locked_st = st_reg == sld_pkg::SLD_ST_LOCKED;

	always_ff @(posedge I_CORE_CLK) begin
		if (!I_RST_N) begin
			rate_reg <= sld_pkg::SLD_RT_3G;
			hunt_reg <= '0;
		end else if (!ctrl_reg.auto_rate) begin
			rate_reg <= sld_pkg::sld_rate_t'(ctrl_reg.man_rate); // [R12]
			hunt_reg <= '0;
		end else if (!stream_valid) begin
			rate_reg <= sld_pkg::SLD_RT_3G; // [R13]
			hunt_reg <= '0;
		end else if (locked_st || stby) begin
			hunt_reg <= '0;
		end else if (bit_en) begin
			if (hunt_reg >= win3) begin
				hunt_reg <= '0;
				rate_reg <= rate_step; // [R11]
			end else
				hunt_reg <= 19'(hunt_reg + 19'h00001);
		end
	end

	// ************************************************************
	// Lock state machine
	// ************************************************************
	logic       lock_reg;
	logic [5:0] stat_reg;
	logic [5:0] stat_next;
	logic [9:0] word_reg;
	logic       wvalid_reg;

	wire noise_ok = !(ctrl_reg.noise && ctrl_reg.auto_rate)
		|| pair_al_reg; // [R5]
	wire cond_ok = pll && (dthru_m // [R3] [R19]
		|| (smpte_m && pair_reg && noise_ok) // [R4]
		|| (asi_m && asi_ok_reg)); // [R6]

	always_comb begin
		st_next = st_reg;
		case (st_reg)
			sld_pkg::SLD_ST_INVALID:
				if (stream_valid) st_next = sld_pkg::SLD_ST_HUNT; // [R10]
			sld_pkg::SLD_ST_HUNT:
				if (cond_ok) st_next = sld_pkg::SLD_ST_LOCKED;
			sld_pkg::SLD_ST_LOCKED:
				if (!cond_ok) st_next = sld_pkg::SLD_ST_HUNT; // [R17]
			default:
				st_next = sld_pkg::SLD_ST_INVALID;
		endcase
		if (!stream_valid)
			st_next = sld_pkg::SLD_ST_INVALID; // [R9] [R13]
		if (stby)
			st_next = st_reg; // [R7]
	end

	generate
		for (genvar i = 0; i < 6; i++) begin : g_stat
			assign stat_next[i] = lock_reg
				&& (ctrl_reg.lock_sel == 3'(i)); // [R2]
		end
	endgenerate

	wire smpte_word = chk_reg && aligned_reg && (ph_reg == align_ph_reg);

	always_ff @(posedge I_CORE_CLK) begin
		if (!I_RST_N) begin
			st_reg     <= sld_pkg::SLD_ST_INVALID; // [R8]
			lock_reg   <= 1'b0;
			stat_reg   <= '0;
			word_reg   <= '0;
			wvalid_reg <= 1'b0;
		end else begin
			st_reg     <= st_next; // [R8]
			lock_reg   <= st_next == sld_pkg::SLD_ST_LOCKED; // [R7]
			stat_reg   <= stat_next;
			wvalid_reg <= smpte_word || (asi_word && asi_m);
			if (smpte_word)
				word_reg <= hist_reg[29:20]; // [R16]
			else if (asi_word && asi_m)
				word_reg <= raw_reg;
		end
	end

	// ************************************************************
	// APB register file
	// ************************************************************
	logic [31:0] prdata_reg;
	logic [31:0] ctrl_word;
	logic [31:0] stat_word;

	wire [9:0] idx    = I_PADDR[11:2];
	wire hit_ctrl     = idx == `SLD_IDX_CTRL;
	wire hit_stat     = idx == `SLD_IDX_STATUS;
	wire hit_noise    = idx == `SLD_IDX_NOISE;
	wire hit_any      = hit_ctrl || hit_stat || hit_noise;
	wire setup_ph     = I_PSEL && !I_PENABLE;
	wire wr_en        = I_PSEL && I_PENABLE && I_PWRITE;
	wire [31:0] noise_word = 32'(ctrl_reg.noise) << `SLD_NOISE_BIT;
	wire [31:0] rd_mux = hit_ctrl ? ctrl_word : hit_stat ? stat_word :
		hit_noise ? noise_word : 32'h00000000;

	always_comb begin
		ctrl_word = '0;
		ctrl_word[`SLD_CTRL_AUTO] = ctrl_reg.auto_rate;
		ctrl_word[`SLD_CTRL_RATE_LO +: 2] = ctrl_reg.man_rate;
		ctrl_word[`SLD_CTRL_SEL_LO +: 3] = ctrl_reg.lock_sel;
		stat_word = '0;
		stat_word[`SLD_ST_LOCK] = lock_reg;
		stat_word[`SLD_ST_VALID] = stream_valid;
		stat_word[`SLD_ST_ALIGNED] = aligned_reg;
		stat_word[`SLD_ST_RATE_LO +: 2] = rate_reg;
		stat_word[`SLD_ST_ASI] = asi_ok_reg;
		stat_word[`SLD_ST_PAIR] = pair_reg;
	end

	// Read data is latched in the setup phase so the bus sees no wait
	always_ff @(posedge I_CORE_CLK) begin
		if (!I_RST_N) begin
			prdata_reg <= '0;
			ctrl_reg   <= '{`SLD_AUTO_RST, `SLD_RATE_RST,
				`SLD_SEL_RST, `SLD_NOISE_RST}; // [R11] [R2]
		end else begin
			if (setup_ph && !I_PWRITE)
				prdata_reg <= rd_mux;
			if (wr_en && hit_ctrl) begin
				ctrl_reg.auto_rate <= I_PWDATA[`SLD_CTRL_AUTO];
				ctrl_reg.man_rate  <= I_PWDATA[`SLD_CTRL_RATE_LO +: 2];
				ctrl_reg.lock_sel  <= I_PWDATA[`SLD_CTRL_SEL_LO +: 3];
			end
			if (wr_en && hit_noise)
				ctrl_reg.noise <= I_PWDATA[`SLD_NOISE_BIT]; // [R5]
		end
	end

	assign O_PRDATA     = prdata_reg;
	assign O_PREADY     = 1'b1;
	assign O_PSLVERR    = I_PSEL && I_PENABLE && !hit_any;
	assign O_STAT       = stat_reg;
	assign O_LOCKED     = lock_reg;
	assign O_RATE       = rate_reg;
	assign O_WORD       = word_reg;
	assign O_WORD_VALID = wvalid_reg;

	// ************************************************************
	// Assertions
	// ************************************************************
	default clocking cb @(posedge I_CORE_CLK); endclocking
	default disable iff (!I_RST_N);

	sequence s_dthru_ready;
		(dthru_m && pll && stream_valid && !stby)[*3];
	endsequence

	a_dthru_lock: assert property (s_dthru_ready |-> lock_reg) // [R3]
		else $error("data-through lock not raised");
	a_smpte_pair: assert property ( // [R4]
		$rose(lock_reg) && $past(smpte_m) |-> $past(pair_reg && pll))
		else $error("SMPTE lock without TRS pair");
	a_noise_align: assert property ( // [R5]
		$rose(lock_reg) && $past(smpte_m && ctrl_reg.noise
		&& ctrl_reg.auto_rate) |-> $past(pair_al_reg))
		else $error("noise-immune lock with differing alignment");
	a_asi_lock: assert property ( // [R6]
		$rose(lock_reg) && $past(asi_m) |-> $past(asi_ok_reg))
		else $error("ASI lock without good word run");
	a_asi_run32: assert property ( // [R6]
		$rose(asi_ok_reg) |-> $past(run_reg) == 6'h1F)
		else $error("ASI sync not after 32 good words");
	a_stby_hold: assert property (stby |=> $stable(lock_reg)) // [R7]
		else $error("lock changed in standby");
	a_invalid_low: assert property ( // [R9]
		!stream_valid && !stby |=> !lock_reg)
		else $error("lock high without valid input");
	a_rate_manual: assert property ( // [R12]
		!ctrl_reg.auto_rate |=> rate_reg == $past(ctrl_reg.man_rate))
		else $error("manual rate not followed");
	a_gap_unlock: assert property ( // [R13]
		act_reg == GAP_CYC && !stby |=> !lock_reg
		&& (!$past(ctrl_reg.auto_rate)
		|| rate_reg == sld_pkg::SLD_RT_3G))
		else $error("lock or rate kept after long gap");
	a_align_commit: assert property ( // [R16]
		$rose(aligned_reg) |-> $past(trs_hit && same_al && align_en))
		else $error("alignment committed without matching TRS");
	a_stat_route: assert property ( // [R2]
		lock_reg && ctrl_reg.lock_sel == 3'h3 |=> O_STAT == 6'h08)
		else $error("lock not on selected status pin");

endmodule // sld_lock_align

/* sld_regs.svh */
// Register offsets, field positions, reset values and timing counts
`ifndef SLD_REGS_SVH
`define SLD_REGS_SVH

// Register word indices (byte address is four times the index)
`define SLD_IDX_CTRL    10'h000
`define SLD_IDX_STATUS  10'h001
`define SLD_IDX_NOISE   10'h085

// Control fields
`define SLD_CTRL_AUTO    0
`define SLD_CTRL_RATE_LO 1
`define SLD_CTRL_SEL_LO  4
`define SLD_NOISE_BIT    10

// Status fields
`define SLD_ST_LOCK     0
`define SLD_ST_VALID    1
`define SLD_ST_ALIGNED  2
`define SLD_ST_RATE_LO  3
`define SLD_ST_ASI      5
`define SLD_ST_PAIR     6

// Reset values
`define SLD_AUTO_RST    1'h1
`define SLD_RATE_RST    2'h0
`define SLD_SEL_RST     3'h3
`define SLD_NOISE_RST   1'h0

// Timing and framing
`define SLD_CLK_MHZ     100
`define SLD_GAP_US      10
`define SLD_GAP_CYC     ((`SLD_GAP_US) * (`SLD_CLK_MHZ))
`define SLD_ASI_RUN     32
`define SLD_ASI_WIN     128
`define SLD_HUNT_LINES  3
`define SLD_K28_NEG     10'h17C
`define SLD_K28_POS     10'h283

`endif

/* sld_pkg.sv */
// Types shared by the lock detect and word align block
package sld_pkg;

	typedef enum logic [1:0] {
		SLD_RT_HD = 2'h0,
		SLD_RT_SD = 2'h1,
		SLD_RT_3G = 2'h2
	} sld_rate_t;

	typedef enum logic [1:0] {
		SLD_ST_INVALID = 2'h0,
		SLD_ST_HUNT    = 2'h1,
		SLD_ST_LOCKED  = 2'h3
	} sld_state_t;

	typedef struct packed {
		logic       auto_rate;
		logic [1:0] man_rate;
		logic [2:0] lock_sel;
		logic       noise;
	} sld_ctrl_t;

	typedef struct packed {
		logic ser_clk;
		logic ser_data;
		logic pll;
		logic vpe;
		logic asi;
		logic stby;
		logic mism;
	} sld_pins_t;

endpackage

/* sld_src_model.sv */
// Behavioural serial video source feeding the lock detect block
`timescale 1ns/1ns

module sld_src_model (
	// Recovered serial link
	output logic o_ser_clk,
	output logic o_ser_data
);

	logic [8:0] scr_reg;
	logic       nrzi_reg;

	initial begin
		o_ser_clk  = 1'b0;
		o_ser_data = 1'b0;
		scr_reg    = 9'h000;
		nrzi_reg   = 1'b0;
	end

	// Clock runs only inside frames; the idle line shows the inverse of
	// the last bit so a stale sample can never pass for real data
	task automatic send_word(input logic [9:0] w, input logic raw);
		logic b;
		for (int i = 0; i < 10; i++) begin
			b = w[i];
			if (!raw) begin
				b = b ^ scr_reg[3] ^ scr_reg[8];
				scr_reg = {scr_reg[7:0], b};
				nrzi_reg = nrzi_reg ^ b;
				b = nrzi_reg;
			end
			// Callers start on a core edge; these offsets keep every pin
			// change off the 10 ns sampling grid
			#31 o_ser_data = b;
			#31 o_ser_clk = 1'b1;
			#62 o_ser_clk = 1'b0;
			o_ser_data = ~b;
			#1;
		end
	endtask

	// One line of 30 words, two headers 150 bits apart
	task automatic send_line(input logic [9:0] h0, h1, h2);
		logic [9:0] w;
		for (int i = 0; i < 30; i++) begin
			case (i % 15)
				0: w = h0;
				1: w = h1;
				2: w = h2;
				3: w = 10'h274;
				default: w = 10'h200;
			endcase
			send_word(w, 1'b0);
		end
	endtask

endmodule // sld_src_model

/* sld_lock_align_tb.sv */
// Self-checking bench for the lock detect and word align block
`timescale 1ns/1ns

module sld_lock_align_tb;

	// ****************
	// Signals
	// ****************
	logic              clk;
	logic              rst_n;
	logic              psel;
	logic              penable;
	logic              pwrite;
	logic [11:0]       paddr;
	logic [31:0]       pwdata;
	logic [31:0]       prdata;
	logic              pready;
	logic              pslverr;
	logic              ser_clk;
	logic              ser_data;
	sld_pkg::sld_pins_t pins;
	logic [5:0]        stat;
	logic              locked;
	logic [1:0]        rate;
	logic [9:0]        word;
	logic              word_valid;
	logic [31:0]       rd;
	logic              err;
	int                failures;
	int                total_checks;
	int                trs_seen;
	logic [8:0]        rows [7] = '{{3'h0, 6'h01}, {3'h1, 6'h02},
		{3'h2, 6'h04}, {3'h3, 6'h08}, {3'h4, 6'h10}, {3'h5, 6'h20},
		{3'h6, 6'h00}};

	// ****************
	// Design and source
	// ****************
	sld_lock_align #(
		.LINE_BITS_SD(200),
		.LINE_BITS_HD(300),
		.LINE_BITS_3G(400)
	) dut (
		.I_CORE_CLK               (clk),
		.I_RST_N                  (rst_n),
		.I_PSEL                   (psel),
		.I_PENABLE                (penable),
		.I_PWRITE                 (pwrite),
		.I_PADDR                  (paddr),
		.I_PWDATA                 (pwdata),
		.O_PRDATA                 (prdata),
		.O_PREADY                 (pready),
		.O_PSLVERR                (pslverr),
		.I_SER_CLK                (ser_clk),
		.I_SER_DATA               (ser_data),
		.I_PLL_LOCKED             (pins.pll),
		.I_VIDEO_PROCESSING_ENABLE(pins.vpe),
		.I_ASI_MODE_SELECT        (pins.asi),
		.I_STANDBY                (pins.stby),
		.I_LEVEL_B_WIDTH_MISMATCH (pins.mism),
		.O_STAT                   (stat),
		.O_LOCKED                 (locked),
		.O_RATE                   (rate),
		.O_WORD                   (word),
		.O_WORD_VALID             (word_valid)
	);

	sld_src_model src (
		.o_ser_clk (ser_clk),
		.o_ser_data(ser_data)
	);

	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end

	always @(posedge clk)
		if (word_valid === 1'b1 && word === 10'h3FF)
			trs_seen++;

	// ****************
	// Tasks
	// ****************
	task automatic check(input string nm, input logic [31:0] seen, exp);
		total_checks++;
		if (seen !== exp) begin
			failures++;
			$display("MISMATCH %s expected %0h seen %0h", nm, exp, seen);
		end
	endtask

	task automatic apb(input logic wr, input logic [11:0] a,
		input logic [31:0] d);
		@(posedge clk);
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'b1;
		do begin
			@(posedge clk);
		end while (pready !== 1'b1);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	// Bits from high: pll, processing enable, asi, standby, mismatch
	task automatic mode(input logic [4:0] m);
		@(posedge clk);
		// PLL lock stands for the acquisition reference being present
		pins <= {2'h0, m};
		repeat (6) @(posedge clk);
	endtask

	task automatic settle();
		repeat (10) @(posedge clk);
	endtask

	task automatic do_reset();
		@(posedge clk);
		rst_n <= 1'b0;
		repeat (20) @(posedge clk);
		rst_n <= 1'b1;
		@(posedge clk);
	endtask

	task automatic end_test(input string nm);
		$display("test %s done, %0d checks so far", nm, total_checks);
	endtask

	task automatic summarize();
		$display("checks %0d, failures %0d", total_checks, failures);
		if (failures == 0 && total_checks > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask

	// ****************
	// Tests
	// ****************
	initial begin
		rst_n = 1'b0;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 12'h000;
		pwdata = 32'h00000000;
		pins = '0;
		failures = 0;
		total_checks = 0;
		trs_seen = 0;
		do_reset();
		check("locked", locked, 1'b0);
		check("rate", rate, sld_pkg::SLD_RT_3G);
		apb(1'b0, 12'h000, 32'h0);
		check("ctrl", rd, 32'h00000031);
		apb(1'b0, 12'h214, 32'h0);
		check("noise", rd, 32'h00000000);
		apb(1'b0, 12'h008, 32'h0);
		check("unmapped err", err, 1'b1);
		check("unmapped data", rd, 32'h00000000);
		mode(5'h10);
		repeat (50) @(posedge clk);
		check("no stream", locked, 1'b0);
		for (int i = 0; i < 4; i++)
			src.send_word(10'h200, 1'b0);
		settle();
		check("dt lock", locked, 1'b1);
		check("stat default", stat, 6'h08);
		for (int i = 0; i < 7; i++) begin
			apb(1'b1, 12'h000, {25'h0, rows[i][8:6], 4'h1});
			settle();
			check("stat sel", stat, rows[i][5:0]);
		end
		mode(5'h02);
		settle();
		check("standby hold", locked, 1'b1);
		mode(5'h00);
		settle();
		check("pll lost", locked, 1'b0);
		mode(5'h10);
		src.send_word(10'h200, 1'b0);
		settle();
		check("relock", locked, 1'b1);
		repeat (800) @(posedge clk);
		check("short gap", locked, 1'b1);
		repeat (300) @(posedge clk);
		check("long gap", locked, 1'b0);
		end_test("data-through");

		do_reset();
		apb(1'b1, 12'h000, 32'h00000030);
		mode(5'h18);
		trs_seen = 0;
		for (int i = 0; i < 3; i++)
			src.send_line(10'h3FF, 10'h000, 10'h000);
		settle();
		check("smpte lock", locked, 1'b1);
		check("manual rate", rate, sld_pkg::SLD_RT_HD);
		check("trs words", trs_seen > 0, 1'b1);
		mode(5'h08);
		settle();
		check("smpte no pll", locked, 1'b0);
		mode(5'h18);
		for (int i = 0; i < 3; i++)
			src.send_line(10'h200, 10'h200, 10'h200);
		settle();
		check("trs stop", locked, 1'b0);
		end_test("smpte manual");

		do_reset();
		apb(1'b1, 12'h000, 32'h00000030);
		mode(5'h18);
		for (int i = 0; i < 2; i++)
			src.send_line(10'h3FC, 10'h003, 10'h001);
		settle();
		check("short header lock", locked, 1'b1);
		end_test("short header");

		do_reset();
		mode(5'h18);
		for (int i = 0; i < 4; i++)
			src.send_line(10'h200, 10'h200, 10'h200);
		for (int i = 0; i < 5; i++)
			src.send_word(10'h200, 1'b0);
		settle();
		check("auto step", rate, sld_pkg::SLD_RT_HD);
		check("hunt unlocked", locked, 1'b0);
		apb(1'b1, 12'h214, 32'h00000400);
		apb(1'b0, 12'h214, 32'h0);
		check("noise bit", rd, 32'h00000400);
		for (int i = 0; i < 3; i++)
			src.send_line(10'h3FF, 10'h000, 10'h000);
		settle();
		check("auto lock", locked, 1'b1);
		apb(1'b0, 12'h004, 32'h0);
		check("aligned", rd[2], 1'b1);
		end_test("smpte auto");

		do_reset();
		apb(1'b1, 12'h000, 32'h00000030);
		mode(5'h14);
		src.send_word(10'h17C, 1'b1);
		for (int i = 0; i < 30; i++)
			src.send_word(10'h2AA, 1'b1);
		settle();
		check("asi short run", locked, 1'b0);
		for (int i = 0; i < 4; i++)
			src.send_word(10'h2AA, 1'b1);
		settle();
		check("asi lock", locked, 1'b1);
		do_reset();
		check("reset clears", locked, 1'b0);
		end_test("asi");

		apb(1'b1, 12'h000, 32'h00000030);
		mode(5'h19);
		for (int i = 0; i < 4; i++)
			src.send_word(10'h200, 1'b0);
		settle();
		check("mismatch lock", locked, 1'b1);
		apb(1'b0, 12'h004, 32'h0);
		check("mismatch align", rd[2], 1'b0);
		end_test("width mismatch");
		summarize();
	end

	initial begin
		repeat (98000) @(posedge clk);
		failures++;
		summarize();
	end

endmodule // sld_lock_align_tb
